/* design/ece_pkg.sv */
// Purpose: Shared constants and types for the electronic cam engine
// Assumes: One clock, ref_clk at 40 MHz, asynchronous active-low reset
// Notes:   Axis counts are parameters in the top; cam-point store capacity is fixed here
package ece_pkg;

  // ****************************************
  // Store geometry
  // ****************************************
  localparam int unsigned ECE_STORE_DEPTH = 1600;
  localparam int unsigned ECE_IDX_W = 11;
  localparam logic [10:0] ECE_TBL_MIN = 11'h003;
  localparam logic [10:0] ECE_TBL_MAX = 11'h640;
  localparam int unsigned ECE_POS_W = 32;

  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [2:0] {
    ECE_CMD_NONE = 3'b000,
    ECE_CMD_ENGAGE = 3'b001,
    ECE_CMD_ENGAGE_POS = 3'b010,
    ECE_CMD_OFF = 3'b011,
    ECE_CMD_OFF_RAMP = 3'b100,
    ECE_CMD_POINT = 3'b101
  } ece_cmd_t;

  // Per-slave follow state
  typedef enum logic [1:0] {
    ECE_ST_IDLE = 2'b00,
    ECE_ST_ARMED = 2'b01,
    ECE_ST_FOLLOW = 2'b10,
    ECE_ST_RAMP = 2'b11
  } ece_state_t;

  // Reset values
  localparam logic [31:0] ECE_POS_RST = 32'h0000_0000;
  localparam logic [10:0] ECE_IDX_RST = 11'h000;

endpackage

/* design/ece_slave_step.sv */
// Purpose: Acceleration clamp for one slave velocity step
// Assumes: Combinational, one shared instance, used only for the served axis while it ramps down
// Notes:   Velocity change limited to +/- max acceleration each cycle
module ece_slave_step (
  input wire logic signed [31:0] vel_now,
  input wire logic signed [31:0] vel_want,
  input wire logic [31:0] acc_max,
  output logic signed [31:0] vel_next
);
  import ece_pkg::*;

  logic signed [32:0] diff;
  logic signed [32:0] lim;

  always_comb begin
    diff = 33'(vel_want) - 33'(vel_now);
    lim = $signed({1'b0, acc_max});
    if (diff > lim) begin
      vel_next = 32'(33'(vel_now) + lim);
    end else if (diff < -lim) begin
      vel_next = 32'(33'(vel_now) - lim);
    end else begin
      vel_next = vel_want;
    end
  end
endmodule

/* design/ece_top.sv */
// Purpose: Electronic cam engine, slaves follow a master by cam tables
// Assumes: Commands are one-cycle strobes; one axis served per cycle
// Notes:   The master position is supplied from outside; this block makes
//          slave positions and the master halt request
module ece_top #(
  parameter int unsigned NUM_AXES = 4,
  parameter int unsigned AXIS_W = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire ece_pkg::ece_cmd_t cmd_code,
  input wire logic [AXIS_W-1:0] cmd_slave,
  input wire logic [10:0] cmd_tbl_start,
  input wire logic [10:0] cmd_tbl_len,
  input wire logic [10:0] cmd_point_idx,
  input wire logic signed [31:0] cmd_master_pos,
  input wire logic signed [31:0] cmd_slave_pos,
  input wire logic signed [31:0] master_pos,
  input wire logic master_stopped,
  input wire logic [31:0] max_acceleration_setting,
  input wire logic emergency_halt_input,
  output logic cmd_done,
  output logic cmd_error,
  output logic master_halt,
  output logic [NUM_AXES-1:0] slave_engaged,
  output logic [NUM_AXES-1:0] slave_halted,
  output logic [NUM_AXES*32-1:0] slave_pos,
  output logic [NUM_AXES*11-1:0] slave_table_index
);
  import ece_pkg::*;

  // ****************************************
  // Cam-point store
  // ****************************************
  // Written only here; reads are indexed per served axis
  logic signed [31:0] pt_master [ECE_STORE_DEPTH];
  logic signed [31:0] pt_slave [ECE_STORE_DEPTH];

  typedef struct packed {
    ece_state_t st;
    logic [10:0] start;
    logic [10:0] len;
    logic [10:0] idx;
    logic signed [31:0] base_m;
    logic signed [31:0] base_s;
    logic signed [31:0] trig;
    logic signed [31:0] pos;
    logic signed [31:0] vel;
    logic signed [31:0] last_m;
  } ece_axis_t;

  typedef struct packed {
    ece_axis_t [NUM_AXES-1:0] ax;
    logic [AXIS_W-1:0] svc;
    logic halt;
    logic [NUM_AXES-1:0] hlt;
    logic done;
    logic err;
  } ece_state_all_t;

  ece_state_all_t st_r;
  ece_state_all_t st_nxt;

  // Range check shared by engage and point write
  function automatic logic tbl_ok(input logic [10:0] s, input logic [10:0] l);
    logic [11:0] sum;
    sum = {1'b0, s} + {1'b0, l};
    tbl_ok = (l >= ECE_TBL_MIN) && (l <= ECE_TBL_MAX) &&
             (sum <= {1'b0, ECE_TBL_MAX});
  endfunction

  function automatic logic [10:0] addr_of(input logic [10:0] s,
                                          input logic [10:0] i);
    logic [11:0] a;
    a = {1'b0, s} + {1'b0, i};
    addr_of = a[10:0];
  endfunction

  logic cmd_ok;
  logic wr_pt;
  logic [10:0] wr_addr;
  ece_axis_t cur;
  logic [10:0] a_lo;
  logic [10:0] a_hi;
  logic [10:0] a_end;
  logic signed [31:0] seg_m0;
  logic signed [31:0] seg_m1;
  logic signed [31:0] seg_s0;
  logic signed [31:0] seg_s1;
  logic signed [31:0] cyc_m;
  logic signed [31:0] cyc_s;
  logic signed [31:0] vel_lim;

  // ****************************************
  // Served-axis lookups
  // ****************************************
  always_comb begin
    cur = st_r.ax[st_r.svc];
    a_lo = addr_of(cur.start, cur.idx);
    a_hi = addr_of(cur.start, cur.idx + 11'h001);
    a_end = addr_of(cur.start, cur.len - 11'h001);
    seg_m0 = pt_master[a_lo];
    seg_m1 = pt_master[a_hi];
    seg_s0 = pt_slave[a_lo];
    seg_s1 = pt_slave[a_hi];
    cyc_m = pt_master[a_end];
    cyc_s = pt_slave[a_end];
  end

  ece_slave_step u_step (
    .vel_now(cur.vel),
    .vel_want(32'sh0000_0000),
    .acc_max(max_acceleration_setting),
    .vel_next(vel_lim)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic signed [31:0] rel;
    logic signed [63:0] num;
    logic signed [31:0] tgt;
    logic signed [31:0] span;
    logic [10:0] nidx;
    logic signed [31:0] dv;
    rel = 32'sh0000_0000;
    num = 64'sh0000_0000_0000_0000;
    tgt = 32'sh0000_0000;
    span = 32'sh0000_0000;
    nidx = 11'h000;
    dv = 32'sh0000_0000;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.err = 1'b0;
    wr_pt = 1'b0;
    wr_addr = addr_of(cmd_tbl_start, cmd_point_idx);
    cmd_ok = tbl_ok(cmd_tbl_start, cmd_tbl_len);
    st_nxt.svc = AXIS_W'((32'(st_r.svc) + 1) % NUM_AXES);

    // Emergency halt: master stop first, slaves once it reports still
    if (emergency_halt_input) begin
      st_nxt.halt = 1'b1;
    end
    if (st_r.halt && master_stopped) begin
      st_nxt.hlt = '1;
    end

    // Cam follow for the served axis; halted slaves stay engaged
    if (!st_r.hlt[st_r.svc]) begin
      case (cur.st)
        ECE_ST_ARMED: begin
          if (master_pos >= cur.trig) begin
            st_nxt.ax[st_r.svc].st = ECE_ST_FOLLOW;
            st_nxt.ax[st_r.svc].base_m = master_pos;
            st_nxt.ax[st_r.svc].base_s = cur.pos;
          end
        end
        ECE_ST_FOLLOW: begin
          rel = master_pos - cur.base_m;
          if (cyc_m != 0 && rel >= cyc_m) begin
            st_nxt.ax[st_r.svc].base_m = cur.base_m + cyc_m;
            st_nxt.ax[st_r.svc].base_s = cur.base_s + cyc_s;
            st_nxt.ax[st_r.svc].idx = ECE_IDX_RST;
          end else begin
            nidx = cur.idx;
            if (rel >= seg_m1 && cur.idx + 11'h002 < cur.len) begin
              nidx = cur.idx + 11'h001;
            end else if (rel < seg_m0 && cur.idx != 11'h000) begin
              nidx = cur.idx - 11'h001;
            end
            st_nxt.ax[st_r.svc].idx = nidx;
            span = seg_m1 - seg_m0;
            if (span != 0) begin
              num = 64'(rel - seg_m0) * 64'(seg_s1 - seg_s0);
              tgt = seg_s0 + 32'(num / 64'(span));
            end else begin
              tgt = seg_s0;
            end
            tgt = tgt + cur.base_s;
            dv = tgt - cur.pos;
            if (dv - cur.vel > $signed(max_acceleration_setting)) begin
              dv = cur.vel + $signed(max_acceleration_setting);
            end else if (cur.vel - dv > $signed(max_acceleration_setting))
            begin
              dv = cur.vel - $signed(max_acceleration_setting);
            end
            st_nxt.ax[st_r.svc].vel = dv;
            st_nxt.ax[st_r.svc].pos = cur.pos + dv;
          end
        end
        ECE_ST_RAMP: begin
          st_nxt.ax[st_r.svc].vel = vel_lim;
          st_nxt.ax[st_r.svc].pos = cur.pos + vel_lim;
          if (vel_lim == 0) begin
            st_nxt.ax[st_r.svc].st = ECE_ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    // Host commands; rejection changes no axis state, it only sets done and error
    if (cmd_valid) begin
      st_nxt.done = 1'b1;
      case (cmd_code)
        ECE_CMD_ENGAGE, ECE_CMD_ENGAGE_POS: begin
          if (!cmd_ok) begin
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.ax[cmd_slave].start = cmd_tbl_start;
            st_nxt.ax[cmd_slave].len = cmd_tbl_len;
            st_nxt.ax[cmd_slave].idx = ECE_IDX_RST;
            st_nxt.ax[cmd_slave].base_m = master_pos;
            st_nxt.ax[cmd_slave].base_s = st_r.ax[cmd_slave].pos;
            st_nxt.ax[cmd_slave].trig = cmd_master_pos;
            st_nxt.ax[cmd_slave].st = (cmd_code == ECE_CMD_ENGAGE) ?
              ECE_ST_FOLLOW : ECE_ST_ARMED;
          end
        end
        ECE_CMD_OFF: begin
          st_nxt.ax[cmd_slave].st = ECE_ST_IDLE;
          st_nxt.ax[cmd_slave].vel = ECE_POS_RST;
        end
        ECE_CMD_OFF_RAMP: begin
          if (st_r.ax[cmd_slave].st != ECE_ST_IDLE) begin
            st_nxt.ax[cmd_slave].st = ECE_ST_RAMP;
          end
        end
        ECE_CMD_POINT: begin
          if (!cmd_ok || cmd_point_idx >= cmd_tbl_len) begin
            st_nxt.err = 1'b1;
          end else begin
            wr_pt = 1'b1;
          end
        end
        default: begin
          st_nxt.err = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Store has no reset: contents are host-loaded before any engage
  always_ff @(posedge ref_clk) begin
    if (wr_pt) begin
      pt_master[wr_addr] <= cmd_master_pos;
      pt_slave[wr_addr] <= cmd_slave_pos;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    cmd_done = st_r.done;
    cmd_error = st_r.err;
    master_halt = st_r.halt;
    slave_halted = st_r.hlt;
    for (int i = 0; i < NUM_AXES; i++) begin
      // Armed slaves wait on the trigger, so they count as disengaged
      slave_engaged[i] = (st_r.ax[i].st == ECE_ST_FOLLOW) ||
        (st_r.ax[i].st == ECE_ST_RAMP);
      slave_pos[i*32 +: 32] = st_r.ax[i].pos;
      slave_table_index[i*11 +: 11] = st_r.ax[i].idx;
    end
  end
endmodule

/* verif/ece_top_assertions.sv */
// Purpose: Port assertions for the cam engine
// Assumes: Bound to ece_top, one clock domain
// Notes:   Slave positions are judged by the bench, not here
module ece_top_assertions #(
  parameter int unsigned NUM_AXES = 4,
  parameter int unsigned AXIS_W = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire ece_pkg::ece_cmd_t cmd_code,
  input wire logic [AXIS_W-1:0] cmd_slave,
  input wire logic [10:0] cmd_tbl_start,
  input wire logic [10:0] cmd_tbl_len,
  input wire logic [10:0] cmd_point_idx,
  input wire logic emergency_halt_input,
  input wire logic cmd_done,
  input wire logic cmd_error,
  input wire logic master_halt,
  input wire logic [NUM_AXES-1:0] slave_engaged,
  input wire logic [NUM_AXES-1:0] slave_halted
);
  timeunit 1ns;
  timeprecision 1ps;
  import ece_pkg::*;
  // ****************************************
  // Checks
  // ****************************************
  logic tbl_cmd;
  logic bad;
  logic pt_bad;
  assign tbl_cmd = cmd_valid && (cmd_code inside {ECE_CMD_ENGAGE,
    ECE_CMD_ENGAGE_POS, ECE_CMD_POINT});
  assign bad = cmd_tbl_len < 11'h003 || cmd_tbl_len > 11'h640 ||
    {1'b0, cmd_tbl_start} + {1'b0, cmd_tbl_len} > 12'h640;
  assign pt_bad = cmd_code == ECE_CMD_POINT && cmd_point_idx >= cmd_tbl_len;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_done_follows: assert property (cmd_valid |=> cmd_done)
    else $error("done missing after a command");
  a_done_only_cmd: assert property (!cmd_valid |=> !cmd_done)
    else $error("done without a command");
  a_error_with_done: assert property (cmd_error |-> cmd_done)
    else $error("error without done");
  a_table_length: assert property (tbl_cmd &&
    (cmd_tbl_len < 11'h003 || cmd_tbl_len > 11'h640) |=> cmd_error)
    else $error("bad table length accepted");
  a_store_overrun: assert property (tbl_cmd && bad |=> cmd_error)
    else $error("store overrun accepted");
  a_point_range: assert property (tbl_cmd && pt_bad |=> cmd_error)
    else $error("point index beyond table accepted");
  a_good_accept: assert property (tbl_cmd && !bad && !pt_bad
    |=> !cmd_error)
    else $error("legal command refused");
  a_engage_now: assert property (cmd_valid && !bad &&
    cmd_code == ECE_CMD_ENGAGE |=> slave_engaged[$past(cmd_slave)])
    else $error("slave not engaged");
  a_release_now: assert property (cmd_valid &&
    cmd_code == ECE_CMD_OFF |=> !slave_engaged[$past(cmd_slave)])
    else $error("slave not released at once");
  a_halt_prompt: assert property (
    emergency_halt_input |=> master_halt)
    else $error("master not halted");
  a_armed_wait: assert property (cmd_valid && !bad &&
    cmd_code == ECE_CMD_ENGAGE_POS |=> !slave_engaged[$past(cmd_slave)])
    else $error("armed slave shown engaged");
  a_master_first: assert property (|slave_halted |-> master_halt)
    else $error("slave halted before master");
  a_halted_engaged: assert property (!cmd_valid |=>
    ($past(slave_engaged) & $past(slave_halted) & ~slave_engaged) == '0)
    else $error("halted slave left cam");
endmodule

/* verif/ece_master_model.sv */
// Purpose: Master axis model for the cam bench
// Assumes: Moves up one count a cycle until it reaches its target
// Notes:   Holds position at once on a halt but reports still STOP_DLY+1 cycles later, so slow stops show
module ece_master_model #(
  parameter int STOP_DLY = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic signed [31:0] target,
  input wire logic master_halt,
  output logic signed [31:0] master_pos,
  output logic master_stopped
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Motion
  // ****************************************
  int cnt;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      master_pos <= '0;
      master_stopped <= 1'b0;
      cnt <= 0;
    end else if (master_halt) begin
      cnt <= cnt + 1;
      master_stopped <= cnt >= STOP_DLY;
    end else if (master_pos < target) begin
      master_pos <= master_pos + 1;
    end
  end
endmodule

/* verif/electronic_cam_engine_tb_top.sv */
// Purpose: Directed bench for the cam engine
// Assumes: Master axis comes from ece_master_model
// Notes:   Follow positions are compared once the master has settled; the ramp check runs while it moves
module electronic_cam_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ece_pkg::*;
  logic ref_clk, resetn, cmd_valid, master_stopped, emergency_halt_input;
  logic cmd_done, cmd_error, master_halt;
  ece_cmd_t cmd_code;
  logic [1:0] cmd_slave;
  logic [10:0] cmd_tbl_start, cmd_tbl_len, cmd_point_idx;
  logic signed [31:0] cmd_master_pos, cmd_slave_pos, master_pos, tgt, snap;
  logic [31:0] max_acceleration_setting;
  logic [3:0] slave_engaged, slave_halted;
  logic [127:0] slave_pos;
  logic [43:0] slave_table_index;
  int fails, samples_checked, n;
  ece_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_slave(cmd_slave),
    .cmd_tbl_start(cmd_tbl_start), .cmd_tbl_len(cmd_tbl_len),
    .cmd_point_idx(cmd_point_idx), .cmd_master_pos(cmd_master_pos),
    .cmd_slave_pos(cmd_slave_pos), .master_pos(master_pos),
    .master_stopped(master_stopped),
    .max_acceleration_setting(max_acceleration_setting),
    .emergency_halt_input(emergency_halt_input), .cmd_done(cmd_done),
    .cmd_error(cmd_error), .master_halt(master_halt),
    .slave_engaged(slave_engaged), .slave_halted(slave_halted),
    .slave_pos(slave_pos), .slave_table_index(slave_table_index));
  ece_master_model mm_u (.ref_clk(ref_clk), .resetn(resetn), .target(tgt),
    .master_halt(master_halt), .master_pos(master_pos),
    .master_stopped(master_stopped));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(ece_cmd_t c, int s, int b, int l, int i, int m, int v,
      logic e);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_slave <= 2'(s);
    cmd_tbl_start <= 11'(b);
    cmd_tbl_len <= 11'(l);
    cmd_point_idx <= 11'(i);
    cmd_master_pos <= m;
    cmd_slave_pos <= v;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("done", cmd_done, 1);
    chk("error", cmd_error, e);
  endtask
  task automatic go(int t);
    @(posedge ref_clk);
    tgt <= t;
  endtask
  task automatic tmo(int k);
    if (k >= 999) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    {resetn, cmd_valid, emergency_halt_input, cmd_slave} = '0;
    {cmd_tbl_start, cmd_tbl_len, cmd_point_idx} = '0;
    {cmd_master_pos, cmd_slave_pos, tgt} = '0;
    cmd_code = ECE_CMD_NONE;
    max_acceleration_setting = 32'h0001_0000;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      cmd(ECE_CMD_POINT, 0, 0, 3, k, k * 100, k * 200, 0);
      cmd(ECE_CMD_POINT, 0, 10, 3, k, k * 100, -k * 100, 0);
    end
    cmd(ECE_CMD_POINT, 0, 0, 1600, 1599, 0, 0, 0);
    cmd(ECE_CMD_ENGAGE, 1, 0, 2, 0, 0, 0, 1);
    cmd(ECE_CMD_ENGAGE, 1, 0, 1601, 0, 0, 0, 1);
    cmd(ECE_CMD_ENGAGE_POS, 1, 1600, 3, 0, 0, 0, 1);
    cmd(ECE_CMD_POINT, 0, 0, 3, 3, 0, 0, 1);
    cmd(ece_cmd_t'(3'b111), 0, 0, 3, 0, 0, 0, 1);
    chk("engaged", slave_engaged, 0);
    $display("test tables done");
    cmd(ECE_CMD_ENGAGE, 1, 0, 3, 0, 0, 0, 0);
    chk("index1", slave_table_index[11+:11], 0);
    go(50);
    for (n = 0; n < 999 && slave_pos[32+:32] !== 100; n++) @(negedge ref_clk);
    tmo(n);
    // Point 1 becomes (100,100) in use, so later positions show the edit
    cmd(ECE_CMD_POINT, 0, 0, 3, 1, 100, 100, 0);
    go(150);
    for (n = 0; n < 999 && slave_pos[32+:32] !== 250; n++) @(negedge ref_clk);
    tmo(n);
    chk("index1", slave_table_index[11+:11], 1);
    go(250);
    for (n = 0; n < 999 && slave_pos[32+:32] !== 450; n++) @(negedge ref_clk);
    tmo(n);
    chk("index1", slave_table_index[11+:11], 0);
    $display("test follow done");
    cmd(ECE_CMD_ENGAGE_POS, 2, 10, 3, 0, 400, 0, 0);
    chk("engaged2", slave_engaged[2], 0);
    go(400);
    for (n = 0; n < 999 && !slave_engaged[2]; n++) @(negedge ref_clk);
    tmo(n);
    chk("trigger", master_pos, 400);
    go(450);
    for (n = 0; n < 999 && slave_pos[64+:32] !== -50; n++) @(negedge ref_clk);
    tmo(n);
    // Let axis 1 take its own update at the final master position
    repeat (4) @(negedge ref_clk);
    chk("slave1", slave_pos[32+:32], 850);
    $display("test position engage done");
    go(600);
    repeat (20) @(posedge ref_clk);
    // Axis 1 runs at 4 counts an update; a limit of 1 adds 3+2+1
    max_acceleration_setting <= 32'h0000_0001;
    cmd(ECE_CMD_OFF_RAMP, 1, 0, 3, 0, 0, 0, 0);
    snap = slave_pos[32+:32];
    for (n = 0; n < 999 && slave_engaged[1]; n++) @(negedge ref_clk);
    tmo(n);
    repeat (8) @(negedge ref_clk);
    chk("ramp1", slave_pos[32+:32], snap + 6);
    cmd(ECE_CMD_OFF, 2, 0, 3, 0, 0, 0, 0);
    chk("engaged2", slave_engaged[2], 0);
    $display("test release done");
    cmd(ECE_CMD_ENGAGE, 3, 10, 3, 0, 0, 0, 0);
    @(posedge ref_clk);
    emergency_halt_input <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("master_halt", master_halt, 1);
    chk("halted", slave_halted, 0);
    for (n = 0; n < 999 && !slave_halted[3]; n++) @(negedge ref_clk);
    tmo(n);
    chk("engaged3", slave_engaged[3], 1);
    $display("test halt done");
    @(posedge ref_clk);
    resetn <= 1'b0;
    emergency_halt_input <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk("halt_reset", master_halt, 0);
    chk("engaged_reset", slave_engaged, 0);
    $display("test reset done");
    give_verdict();
  end
endmodule
bind ece_top ece_top_assertions #(.NUM_AXES(NUM_AXES), .AXIS_W(AXIS_W))
  chk_u (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_slave(cmd_slave), .cmd_tbl_len(cmd_tbl_len),
  .cmd_tbl_start(cmd_tbl_start), .cmd_point_idx(cmd_point_idx),
  .emergency_halt_input(emergency_halt_input), .cmd_done(cmd_done),
  .cmd_error(cmd_error), .master_halt(master_halt),
  .slave_engaged(slave_engaged), .slave_halted(slave_halted));
